// ---- tpis_pkg.sv ----
// Constants and types shared by the text processor I2C slave
package tpis_pkg;
  localparam logic [6:0] SLV_ADDR      = 7'h11;
  localparam logic [7:0] SUB_CPU_FIX   = 8'h78;
  localparam logic [7:0] SUB_CPU_INC   = 8'h79;
  localparam logic [7:0] SUB_DRAM      = 8'h7a;
  localparam logic [7:0] SUB_CMD       = 8'h7b;
  localparam logic [7:0] SUB_DATA      = 8'h7c;
  localparam logic [7:0] SUB_STATUS    = 8'h7d;
  localparam int         BUF_BYTES     = 48;
  localparam int         CPU_AW        = 16;
  localparam int         DRAM_AW       = 21;
  localparam logic [1:0] CPU_ABYTES    = 2'h2;
  localparam logic [1:0] DRAM_ABYTES   = 2'h3;
  localparam logic [1:0] K_SUB         = 2'h0;
  localparam logic [1:0] K_DATA        = 2'h1;
  localparam logic [1:0] K_STOP        = 2'h2;
  localparam logic [1:0] K_RDREQ       = 2'h3;
  localparam int         ST_WAIT_BIT   = 7;
  localparam int         ST_INV_BIT    = 6;
  localparam int         ST_NODATA_BIT = 5;
  localparam logic [7:0] DUMMY_BYTE    = 8'h00;
  localparam logic [7:0] IDLE_BYTE     = 8'hff;

  typedef enum logic [6:0] {
    L_IDLE  = 7'h01,
    L_RXBIT = 7'h02,
    L_HOLD  = 7'h04,
    L_ACK   = 7'h08,
    L_FETCH = 7'h10,
    L_TXBIT = 7'h20,
    L_TXACK = 7'h40
  } tpis_lst_t;

  typedef enum logic [3:0] {
    S_IDLE = 4'h1,
    S_CPU  = 4'h2,
    S_DRAM = 4'h4,
    S_CMD  = 4'h8
  } tpis_sst_t;

  typedef enum logic [2:0] {
    T_NONE    = 3'h0,
    T_CPU_FIX = 3'h1,
    T_CPU_INC = 3'h2,
    T_DRAM    = 3'h3,
    T_CMD     = 3'h4
  } tpis_tgt_t;
endpackage

// ---- tpis_i2c_slave.sv ----
// Ten-bit word FIFO (kind tag plus byte) and I2C slave front end with link and system clock domains
module tpis_fifo #(
  parameter int W     = 10,
  parameter int DEPTH = 48
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         rst,
  // Fill side
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  // Drain side
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  localparam int AW = $clog2(DEPTH);

  if (DEPTH < 2)
  begin : g_bad_depth
    $error("tpis_fifo: DEPTH must be at least 2");
  end

  logic [W-1:0] mem [DEPTH];
  logic [AW-1:0] wp_r;
  logic [AW-1:0] rp_r;
  logic [AW:0]   cnt_r;
  logic          push;
  logic          pop;

  assign in_ready  = cnt_r != (AW+1)'(DEPTH);
  assign out_valid = cnt_r != '0;
  assign out_data  = mem[rp_r];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  always_ff @(posedge clk)
  begin
    if (push)
      mem[wp_r] <= in_data;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      wp_r  <= '0;
      rp_r  <= '0;
      cnt_r <= '0;
    end
    else
    begin
      if (push)
        wp_r <= (wp_r == AW'(DEPTH-1)) ? '0 : wp_r + 1'b1;
      if (pop)
        rp_r <= (rp_r == AW'(DEPTH-1)) ? '0 : rp_r + 1'b1;
      cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule // tpis_fifo

module tpis_i2c_slave #(
  parameter int BUF_DEPTH = tpis_pkg::BUF_BYTES
) (
  // Clocks and reset
  input  wire logic                         clk,
  input  wire logic                         rst,
  input  wire logic                         link_clk,
  // I2C pins
  input  wire logic                         scl_in,
  output logic                              scl_out,
  output logic                              scl_oe,
  input  wire logic                         sda_in,
  output logic                              sda_out,
  output logic                              sda_oe,
  // CPU memory port
  output logic                              cpu_req,
  output logic [tpis_pkg::CPU_AW-1:0]       cpu_addr,
  input  wire logic [7:0]                   cpu_rdata,
  input  wire logic                         cpu_ack,
  // DRAM port
  output logic                              dram_req,
  output logic [tpis_pkg::DRAM_AW-1:0]      dram_addr,
  input  wire logic [7:0]                   dram_rdata,
  input  wire logic                         dram_ack,
  // Command interpreter port
  output logic                              cmd_req,
  output logic                              cmd_first,
  input  wire logic [7:0]                   cmd_rdata,
  input  wire logic                         cmd_ack,
  input  wire logic                         cmd_wait,
  input  wire logic                         cmd_invalid,
  input  wire logic                         cmd_nodata,
  // Shared access data
  output logic                              acc_we,
  output logic [7:0]                        acc_wdata,
  // Processing state
  output logic                              proc_busy
);
  // Stop counter is six bits wide
  if (BUF_DEPTH < 2 || BUF_DEPTH > 63)
  begin : g_bad_depth
    $error("tpis_i2c_slave: BUF_DEPTH must be 2 to 63");
  end

  tpis_pkg::tpis_lst_t lst_r;
  tpis_pkg::tpis_sst_t sst_r;
  tpis_pkg::tpis_tgt_t tgt_r;

  logic scl_m_r, scl_s_r, scl_p_r, sda_m_r, sda_s_r, sda_p_r;
  logic ack_m_r, ack_s_r, busy_m_r, busy_s_r;
  logic scl_rise, scl_fall, start_c, stop_c, pending, sub_ok;
  logic [7:0] sh_r;
  logic [3:0] bcnt_r;
  logic [1:0] bidx_r;
  logic       rw_r, act_r, fresh_r, pushed_r, mack_r, req_tog_r;
  logic       scl_oe_r, sda_oe_r;
  logic [9:0] word_r;

  logic       req_m_r, req_s_r, req_seen_r, ack_tog_r, new_w, push_acc;
  logic       f_in_ready, f_out_valid, f_out_ready, pop, cmd_gate, reply_w;
  logic       acc_ack, imm_rd, dummy_r, cmd_first_r, acc_we_r;
  logic [9:0] f_out_data;
  logic [1:0] kind;
  logic [7:0] byte_w, sub_r, rd_data_r, acc_rdata, status_w, acc_wdata_r;
  logic [1:0] acnt_r;
  logic [5:0] stop_cnt_r;
  logic [tpis_pkg::CPU_AW-1:0]  cpu_addr_r, cpu_base_r;
  logic [tpis_pkg::DRAM_AW-1:0] dram_wp_r, dram_rp_r;

  // Link domain: pins only ever pull low
  assign scl_out = 1'b0;
  assign sda_out = 1'b0;
  assign scl_oe  = scl_oe_r;
  assign sda_oe  = sda_oe_r;

  always_ff @(posedge link_clk or posedge rst)
  begin
    if (rst)
    begin
      {scl_m_r, scl_s_r, scl_p_r} <= 3'h7;
      {sda_m_r, sda_s_r, sda_p_r} <= 3'h7;
      {ack_m_r, ack_s_r, busy_m_r, busy_s_r} <= 4'h0;
    end
    else
    begin
      {scl_m_r, scl_s_r, scl_p_r} <= {scl_in, scl_m_r, scl_s_r};
      {sda_m_r, sda_s_r, sda_p_r} <= {sda_in, sda_m_r, sda_s_r};
      {ack_m_r, ack_s_r} <= {ack_tog_r, ack_m_r};
      {busy_m_r, busy_s_r} <= {proc_busy, busy_m_r};
    end
  end

  assign scl_rise = scl_s_r & ~scl_p_r;
  assign scl_fall = ~scl_s_r & scl_p_r;
  assign start_c  = scl_s_r & scl_p_r & sda_p_r & ~sda_s_r;
  assign stop_c   = scl_s_r & scl_p_r & ~sda_p_r & sda_s_r;
  assign pending  = req_tog_r != ack_s_r;
  assign sub_ok   = (sh_r >= tpis_pkg::SUB_CPU_FIX) && (sh_r <= tpis_pkg::SUB_STATUS);

  always_ff @(posedge link_clk or posedge rst)
  begin
    if (rst)
    begin
      lst_r     <= tpis_pkg::L_IDLE;
      sh_r      <= 8'h00;
      bcnt_r    <= 4'h0;
      bidx_r    <= 2'h0;
      rw_r      <= 1'b0;
      act_r     <= 1'b0;
      fresh_r   <= 1'b1;
      pushed_r  <= 1'b0;
      mack_r    <= 1'b0;
      req_tog_r <= 1'b0;
      word_r    <= 10'h000;
      scl_oe_r  <= 1'b0;
      sda_oe_r  <= 1'b0;
    end
    else if (start_c)
    begin
      lst_r    <= tpis_pkg::L_RXBIT;
      bcnt_r   <= 4'h0;
      bidx_r   <= 2'h0;
      pushed_r <= 1'b0;
      scl_oe_r <= 1'b0;
      sda_oe_r <= 1'b0;
    end
    else if (stop_c)
    begin
      lst_r    <= tpis_pkg::L_IDLE;
      fresh_r  <= 1'b1;
      pushed_r <= 1'b0;
      scl_oe_r <= 1'b0;
      sda_oe_r <= 1'b0;
      // Stop marker releases buffered command bytes
      if (act_r)
      begin
        act_r     <= 1'b0;
        word_r    <= {tpis_pkg::K_STOP, 8'h00};
        req_tog_r <= ~req_tog_r;
      end
    end
    else
    begin
      case (lst_r)
        tpis_pkg::L_RXBIT:
        begin
          if (scl_rise)
          begin
            sh_r   <= {sh_r[6:0], sda_s_r};
            bcnt_r <= bcnt_r + 4'h1;
          end
          else if (scl_fall && bcnt_r == 4'h8)
          begin
            lst_r    <= tpis_pkg::L_HOLD;
            scl_oe_r <= 1'b1;
          end
        end
        tpis_pkg::L_HOLD:
        begin
          if (bidx_r == 2'h0)
          begin
            // General call and foreign addresses fall through unanswered
            if (sh_r[7:1] != tpis_pkg::SLV_ADDR)
            begin
              lst_r    <= tpis_pkg::L_IDLE;
              scl_oe_r <= 1'b0;
            end
            else if (!(fresh_r && busy_s_r))
            begin
              rw_r     <= sh_r[0];
              act_r    <= 1'b1;
              fresh_r  <= 1'b0;
              lst_r    <= tpis_pkg::L_ACK;
              sda_oe_r <= 1'b1;
            end
          end
          else if (!pushed_r)
          begin
            if (bidx_r == 2'h1 && !sub_ok)
            begin
              lst_r    <= tpis_pkg::L_IDLE;
              scl_oe_r <= 1'b0;
            end
            else if (!pending)
            begin
              word_r    <= {(bidx_r == 2'h1) ? tpis_pkg::K_SUB : tpis_pkg::K_DATA, sh_r};
              req_tog_r <= ~req_tog_r;
              pushed_r  <= 1'b1;
            end
          end
          else if (!pending)
          begin
            pushed_r <= 1'b0;
            lst_r    <= tpis_pkg::L_ACK;
            sda_oe_r <= 1'b1;
          end
        end
        tpis_pkg::L_ACK:
        begin
          // SDA settles a cycle before SCL is let go, never while SCL is high
          scl_oe_r <= 1'b0;
          if (scl_fall)
          begin
            sda_oe_r <= 1'b0;
            bcnt_r   <= 4'h0;
            bidx_r   <= (bidx_r == 2'h2) ? 2'h2 : bidx_r + 2'h1;
            if (rw_r && bidx_r == 2'h0)
            begin
              lst_r    <= tpis_pkg::L_FETCH;
              scl_oe_r <= 1'b1;
            end
            else
              lst_r <= tpis_pkg::L_RXBIT;
          end
        end
        tpis_pkg::L_FETCH:
        begin
          if (!pushed_r && !pending)
          begin
            word_r    <= {tpis_pkg::K_RDREQ, 8'h00};
            req_tog_r <= ~req_tog_r;
            pushed_r  <= 1'b1;
          end
          else if (pushed_r && !pending)
          begin
            sh_r     <= rd_data_r;
            pushed_r <= 1'b0;
            bcnt_r   <= 4'h0;
            sda_oe_r <= ~rd_data_r[7];
            lst_r    <= tpis_pkg::L_TXBIT;
          end
        end
        tpis_pkg::L_TXBIT:
        begin
          scl_oe_r <= 1'b0;
          if (scl_fall)
          begin
            bcnt_r <= bcnt_r + 4'h1;
            if (bcnt_r == 4'h7)
            begin
              sda_oe_r <= 1'b0;
              lst_r    <= tpis_pkg::L_TXACK;
            end
            else
            begin
              sh_r     <= {sh_r[6:0], 1'b0};
              sda_oe_r <= ~sh_r[6];
            end
          end
        end
        tpis_pkg::L_TXACK:
        begin
          if (scl_rise)
            mack_r <= ~sda_s_r;
          else if (scl_fall)
          begin
            lst_r    <= mack_r ? tpis_pkg::L_FETCH : tpis_pkg::L_IDLE;
            scl_oe_r <= mack_r;
          end
        end
        default:
        begin
          scl_oe_r <= 1'b0;
          sda_oe_r <= 1'b0;
        end
      endcase
    end
  end

  // System domain: word handshake from the link
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      {req_m_r, req_s_r} <= 2'h0;
    else
      {req_m_r, req_s_r} <= {req_tog_r, req_m_r};
  end

  assign new_w    = req_s_r != req_seen_r;
  assign push_acc = new_w & f_in_ready;

  // Read requests are answered only once their byte is ready
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      req_seen_r <= 1'b0;
      ack_tog_r  <= 1'b0;
    end
    else
    begin
      if (push_acc)
        req_seen_r <= req_s_r;
      ack_tog_r <= ack_tog_r ^ (push_acc && word_r[9:8] != tpis_pkg::K_RDREQ) ^ reply_w;
    end
  end

  tpis_fifo #(
    .W     (10),
    .DEPTH (BUF_DEPTH)
  ) u_buf (
    .clk       (clk),
    .rst       (rst),
    .in_valid  (new_w),
    .in_ready  (f_in_ready),
    .in_data   (word_r),
    .out_valid (f_out_valid),
    .out_ready (f_out_ready),
    .out_data  (f_out_data)
  );

  assign kind        = f_out_data[9:8];
  assign byte_w      = f_out_data[7:0];
  assign cmd_gate    = kind == tpis_pkg::K_DATA && tgt_r == tpis_pkg::T_CMD
                       && acnt_r == 2'h0 && stop_cnt_r == 6'h00;
  assign f_out_ready = sst_r == tpis_pkg::S_IDLE && !cmd_gate;
  assign pop         = f_out_valid & f_out_ready;
  assign proc_busy   = f_out_valid || sst_r != tpis_pkg::S_IDLE;

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      stop_cnt_r <= 6'h00;
    else
      stop_cnt_r <= stop_cnt_r + 6'(push_acc && word_r[9:8] == tpis_pkg::K_STOP)
                    - 6'(pop && kind == tpis_pkg::K_STOP);
  end

  always_comb
  begin
    status_w = 8'h00;
    status_w[tpis_pkg::ST_WAIT_BIT]   = cmd_wait;
    status_w[tpis_pkg::ST_INV_BIT]    = cmd_invalid;
    status_w[tpis_pkg::ST_NODATA_BIT] = cmd_nodata;
  end

  assign imm_rd    = sub_r == tpis_pkg::SUB_STATUS || tgt_r == tpis_pkg::T_NONE
                     || (tgt_r == tpis_pkg::T_DRAM && dummy_r);
  assign acc_ack   = (sst_r == tpis_pkg::S_CPU && cpu_ack) || (sst_r == tpis_pkg::S_DRAM && dram_ack)
                     || (sst_r == tpis_pkg::S_CMD && cmd_ack);
  assign acc_rdata = (sst_r == tpis_pkg::S_CPU) ? cpu_rdata :
                     (sst_r == tpis_pkg::S_DRAM) ? dram_rdata : cmd_rdata;
  assign reply_w   = (pop && kind == tpis_pkg::K_RDREQ && imm_rd) || (acc_ack && !acc_we_r);

  assign cpu_req   = sst_r == tpis_pkg::S_CPU;
  assign dram_req  = sst_r == tpis_pkg::S_DRAM;
  assign cmd_req   = sst_r == tpis_pkg::S_CMD;
  assign cpu_addr  = cpu_addr_r;
  assign dram_addr = acc_we_r ? dram_wp_r : dram_rp_r;
  assign cmd_first = cmd_first_r;
  assign acc_we    = acc_we_r;
  assign acc_wdata = acc_wdata_r;

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      sst_r       <= tpis_pkg::S_IDLE;
      tgt_r       <= tpis_pkg::T_NONE;
      sub_r       <= 8'h00;
      acnt_r      <= 2'h0;
      dummy_r     <= 1'b0;
      cmd_first_r <= 1'b0;
      acc_we_r    <= 1'b0;
      acc_wdata_r <= 8'h00;
      rd_data_r   <= tpis_pkg::IDLE_BYTE;
      cpu_addr_r  <= '0;
      cpu_base_r  <= '0;
      dram_wp_r   <= '0;
      dram_rp_r   <= '0;
    end
    else if (sst_r != tpis_pkg::S_IDLE)
    begin
      if (acc_ack)
      begin
        sst_r <= tpis_pkg::S_IDLE;
        if (!acc_we_r)
          rd_data_r <= acc_rdata;
        if (tgt_r == tpis_pkg::T_CPU_INC)
          cpu_addr_r <= cpu_addr_r + 1'b1;
        if (tgt_r == tpis_pkg::T_DRAM && acc_we_r)
          dram_wp_r <= dram_wp_r + 1'b1;
        if (tgt_r == tpis_pkg::T_DRAM && !acc_we_r)
          dram_rp_r <= dram_rp_r + 1'b1;
        if (tgt_r == tpis_pkg::T_CMD && acc_we_r)
          cmd_first_r <= 1'b0;
      end
    end
    else if (pop)
    begin
      case (kind)
        tpis_pkg::K_SUB:
        begin
          sub_r <= byte_w;
          if (byte_w == tpis_pkg::SUB_CPU_FIX || byte_w == tpis_pkg::SUB_CPU_INC)
          begin
            tgt_r  <= (byte_w == tpis_pkg::SUB_CPU_FIX) ? tpis_pkg::T_CPU_FIX : tpis_pkg::T_CPU_INC;
            acnt_r <= tpis_pkg::CPU_ABYTES;
          end
          else if (byte_w == tpis_pkg::SUB_DRAM)
          begin
            tgt_r   <= tpis_pkg::T_DRAM;
            acnt_r  <= tpis_pkg::DRAM_ABYTES;
            dummy_r <= 1'b1;
          end
          else if (byte_w == tpis_pkg::SUB_CMD)
          begin
            tgt_r       <= tpis_pkg::T_CMD;
            acnt_r      <= 2'h0;
            cmd_first_r <= 1'b1;
          end
          else if (byte_w == tpis_pkg::SUB_DATA)
          begin
            // Data register restarts at the stored CPU address without increment
            acnt_r     <= 2'h0;
            cpu_addr_r <= cpu_base_r;
            if (tgt_r == tpis_pkg::T_CPU_INC)
              tgt_r <= tpis_pkg::T_CPU_FIX;
            if (tgt_r == tpis_pkg::T_DRAM)
              dummy_r <= 1'b1;
          end
        end
        tpis_pkg::K_DATA:
        begin
          if (acnt_r != 2'h0)
          begin
            acnt_r     <= acnt_r - 2'h1;
            cpu_addr_r <= {cpu_addr_r[7:0], byte_w};
            cpu_base_r <= {cpu_base_r[7:0], byte_w};
            dram_wp_r  <= {dram_wp_r[12:0], byte_w};
            dram_rp_r  <= {dram_rp_r[12:0], byte_w};
          end
          else if (sub_r != tpis_pkg::SUB_STATUS && tgt_r != tpis_pkg::T_NONE)
          begin
            acc_we_r    <= 1'b1;
            acc_wdata_r <= byte_w;
            sst_r       <= (tgt_r == tpis_pkg::T_DRAM) ? tpis_pkg::S_DRAM :
                           (tgt_r == tpis_pkg::T_CMD) ? tpis_pkg::S_CMD : tpis_pkg::S_CPU;
          end
        end
        tpis_pkg::K_RDREQ:
        begin
          acc_we_r <= 1'b0;
          if (sub_r == tpis_pkg::SUB_STATUS)
            rd_data_r <= status_w;
          else if (tgt_r == tpis_pkg::T_NONE)
            rd_data_r <= tpis_pkg::IDLE_BYTE;
          else if (tgt_r == tpis_pkg::T_DRAM && dummy_r)
          begin
            rd_data_r <= tpis_pkg::DUMMY_BYTE;
            dummy_r   <= 1'b0;
          end
          else
            sst_r <= (tgt_r == tpis_pkg::T_DRAM) ? tpis_pkg::S_DRAM :
                     (tgt_r == tpis_pkg::T_CMD) ? tpis_pkg::S_CMD : tpis_pkg::S_CPU;
        end
        default:
        begin
          acnt_r <= 2'h0;
        end
      endcase
    end
  end
endmodule // tpis_i2c_slave

// ---- tpis_sva.sv ----
// Port checker for the text processor I2C slave
module tpis_sva (
  // Clocks and reset
  input wire logic                        clk,
  input wire logic                        rst,
  input wire logic                        link_clk,
  // Link
  input wire logic                        scl_in,
  input wire logic                        scl_oe,
  input wire logic                        sda_oe,
  // Access ports
  input wire logic                        cpu_req,
  input wire logic [tpis_pkg::CPU_AW-1:0]  cpu_addr,
  input wire logic                        cpu_ack,
  input wire logic                        dram_req,
  input wire logic [tpis_pkg::DRAM_AW-1:0] dram_addr,
  input wire logic                        dram_ack,
  input wire logic                        cmd_req,
  input wire logic                        cmd_first,
  input wire logic                        cmd_ack,
  input wire logic                        acc_we,
  input wire logic [7:0]                  acc_wdata,
  input wire logic                        proc_busy
);
  property p_cpu_hold;
    @(posedge clk) disable iff (rst)
    cpu_req && !cpu_ack |=> cpu_req && $stable({cpu_addr, acc_we, acc_wdata});
  endproperty
  a_cpu_hold: assert property (p_cpu_hold)
    else $error("cpu access changed before ack");
  property p_dram_hold;
    @(posedge clk) disable iff (rst)
    dram_req && !dram_ack |=> dram_req && $stable({dram_addr, acc_we, acc_wdata});
  endproperty
  a_dram_hold: assert property (p_dram_hold)
    else $error("dram access changed before ack");
  property p_cmd_hold;
    @(posedge clk) disable iff (rst)
    cmd_req && !cmd_ack |=> cmd_req && $stable({cmd_first, acc_we, acc_wdata});
  endproperty
  a_cmd_hold: assert property (p_cmd_hold)
    else $error("command access changed before ack");
  property p_cpu_end;
    @(posedge clk) disable iff (rst) cpu_req && cpu_ack |=> !cpu_req;
  endproperty
  a_cpu_end: assert property (p_cpu_end)
    else $error("cpu request not dropped after ack");
  property p_dram_end;
    @(posedge clk) disable iff (rst) dram_req && dram_ack |=> !dram_req;
  endproperty
  a_dram_end: assert property (p_dram_end)
    else $error("dram request not dropped after ack");
  property p_one;
    @(posedge clk) disable iff (rst) $onehot0({cpu_req, dram_req, cmd_req});
  endproperty
  a_one: assert property (p_one)
    else $error("two accesses at once");
  property p_busy;
    @(posedge clk) disable iff (rst) $rose(cpu_req || dram_req || cmd_req) |-> $past(proc_busy);
  endproperty
  a_busy: assert property (p_busy)
    else $error("access running while not busy");
  property p_sda;
    @(posedge link_clk) disable iff (rst) $changed(sda_oe) |-> !scl_in;
  endproperty
  a_sda: assert property (p_sda)
    else $error("data line moved while clock high");
  property p_stretch;
    @(posedge link_clk) disable iff (rst) $rose(scl_oe) |-> !$past(scl_in);
  endproperty
  a_stretch: assert property (p_stretch)
    else $error("clock pulled low in high phase");
  c_cpu: cover property (@(posedge clk) cpu_req && cpu_ack && acc_we);
  c_rd: cover property (@(posedge clk) dram_req && dram_ack && !acc_we);
  c_cmd: cover property (@(posedge clk) cmd_req && cmd_ack && cmd_first);
  c_hold: cover property (@(posedge link_clk) scl_oe [*8]);
endmodule // tpis_sva

bind tpis_i2c_slave tpis_sva i_sva (
  .clk(clk), .rst(rst), .link_clk(link_clk), .scl_in(scl_in), .scl_oe(scl_oe),
  .sda_oe(sda_oe), .cpu_req(cpu_req), .cpu_addr(cpu_addr), .cpu_ack(cpu_ack),
  .dram_req(dram_req), .dram_addr(dram_addr), .dram_ack(dram_ack),
  .cmd_req(cmd_req), .cmd_first(cmd_first), .cmd_ack(cmd_ack),
  .acc_we(acc_we), .acc_wdata(acc_wdata), .proc_busy(proc_busy)
);

// ---- tpis_master.sv ----
// I2C bus master model standing in for the TV controller
module tpis_master (
  // Clock
  input  wire logic clk,
  // Wire levels
  input  wire logic scl,
  input  wire logic sda,
  // Open-drain drives, 0 pulls low
  output logic      scl_m,
  output logic      sda_m
);
  timeunit 1ns;
  timeprecision 1ps;
  initial scl_m = 1'b1;
  initial sda_m = 1'b1;
  task automatic hp();
    repeat (20) @(posedge clk);
  endtask
  // Slave may stretch the low phase, so follow the wire
  task automatic rise();
    int n;
    scl_m <= 1'b1;
    for (n = 0; n < 20000 && !scl; n++) @(posedge clk);
    hp();
  endtask
  task automatic bit_x(input logic b, output logic r);
    sda_m <= b;
    hp();
    rise();
    r = sda;
    scl_m <= 1'b0;
    repeat (4) @(posedge clk);
  endtask
  task automatic start();
    sda_m <= 1'b1;
    hp();
    rise();
    sda_m <= 1'b0;
    hp();
    scl_m <= 1'b0;
    repeat (4) @(posedge clk);
  endtask
  task automatic stop();
    sda_m <= 1'b0;
    hp();
    rise();
    sda_m <= 1'b1;
    hp();
  endtask
  // Telegrams stay far below 256 bytes
  task automatic wr(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_x(d[i], r);
    bit_x(1'b1, r);
    ack = !r;
  endtask
  task automatic rd(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) bit_x(1'b1, d[i]);
    bit_x(last, r);
  endtask
endmodule // tpis_master

// ---- tpis_tb.sv ----
// Testbench for the text processor I2C slave
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk = 1'b0, link_clk = 1'b0, rst = 1'b1;
  logic        scl_m, sda_m, scl_oe, sda_oe, cpu_req, dram_req, cmd_req;
  logic        cpu_ack = 1'b0, dram_ack = 1'b0, cmd_ack = 1'b0;
  logic        cmd_wait = 1'b0, cmd_invalid = 1'b0, cmd_nodata = 1'b0;
  logic        cmd_first, acc_we, proc_busy, scl_o, sda_o;
  logic [7:0]  cpu_rdata = 8'h00, dram_rdata = 8'h00, cmd_rdata = 8'h3c, acc_wdata;
  logic [15:0] cpu_addr;
  logic [20:0] dram_addr;
  logic [31:0] q[$];
  int          error_cnt = 0, checks_done = 0, cyc = 0, stall_until = 0;
  int          hold_n = 0, hold_max = 0;
  wire         scl = scl_m & (scl_oe ? scl_o : 1'b1);
  wire         sda = sda_m & (sda_oe ? sda_o : 1'b1);
  initial forever #12.5 clk = ~clk;
  initial
  begin
    #7;
    forever #24 link_clk = ~link_clk;
  end
  tpis_i2c_slave #(.BUF_DEPTH(4)) i_dut (
    .clk(clk), .rst(rst), .link_clk(link_clk), .scl_in(scl), .scl_out(scl_o),
    .scl_oe(scl_oe), .sda_in(sda), .sda_out(sda_o), .sda_oe(sda_oe),
    .cpu_req(cpu_req), .cpu_addr(cpu_addr), .cpu_rdata(cpu_rdata), .cpu_ack(cpu_ack),
    .dram_req(dram_req), .dram_addr(dram_addr), .dram_rdata(dram_rdata),
    .dram_ack(dram_ack), .cmd_req(cmd_req), .cmd_first(cmd_first),
    .cmd_rdata(cmd_rdata), .cmd_ack(cmd_ack), .cmd_wait(cmd_wait),
    .cmd_invalid(cmd_invalid), .cmd_nodata(cmd_nodata), .acc_we(acc_we),
    .acc_wdata(acc_wdata), .proc_busy(proc_busy));
  tpis_master m (.clk(clk), .scl(scl), .sda(sda), .scl_m(scl_m), .sda_m(sda_m));
  // Memory side answers a cycle late, or not at all while stalled
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    hold_n <= scl_oe ? hold_n + 1 : 0;
    if (hold_n > hold_max)
      hold_max <= hold_n;
    cpu_ack <= cpu_req && !cpu_ack && cyc >= stall_until;
    dram_ack <= dram_req && !dram_ack && cyc >= stall_until;
    cmd_ack <= cmd_req && !cmd_ack && cyc >= stall_until;
    cpu_rdata <= cpu_addr[7:0];
    dram_rdata <= dram_addr[7:0];
    if (cpu_req && cpu_ack && acc_we)
      q.push_back({3'h1, 5'h00, cpu_addr, acc_wdata});
    if (dram_req && dram_ack && acc_we)
      q.push_back({3'h2, dram_addr, acc_wdata});
    if (cmd_req && cmd_ack && acc_we)
      q.push_back({3'h3, 20'h00000, cmd_first, acc_wdata});
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic expq(input logic [31:0] e);
    for (int n = 0; n < 3000 && q.size() == 0; n++) @(posedge clk);
    chk(q.size() > 0 ? q.pop_front() : 32'hxxxxxxxx, e);
  endtask
  task automatic send(input logic [7:0] b[$], input bit stp, output logic ok);
    m.start();
    ok = 1'b1;
    foreach (b[i]) if (ok) m.wr(b[i], ok);
    if (stp)
      m.stop();
  endtask
  task automatic rd_stat(input logic [7:0] s, output logic [7:0] d);
    logic ok;
    send({8'h22, s}, 0, ok);
    send({8'h23}, 0, ok);
    m.rd(1'b1, d);
    m.stop();
  endtask
  task automatic t_addr();
    logic ok;
    send({8'h00, 8'h7c}, 1, ok);
    chk(ok, 1'b0);
    send({8'h24, 8'h7c}, 1, ok);
    chk(ok, 1'b0);
    for (int s = 8'h76; s < 8'h80; s++)
    begin
      send({8'h22, 8'(s)}, 1, ok);
      chk(ok, s >= 8'h78 && s <= 8'h7d);
    end
    chk(32'(q.size()), 32'h0);
    $display("t_addr done");
  endtask
  task automatic t_cpu();
    logic       ok;
    logic [7:0] d;
    send({8'h22, 8'h78, 8'h12, 8'h34, 8'haa, 8'hbb}, 1, ok);
    rd_stat(8'h7c, d);
    chk(d, 8'h34);
    send({8'h22, 8'h79, 8'h00, 8'hff, 8'hcc, 8'hdd}, 1, ok);
    send({8'h22, 8'h7c, 8'hee}, 1, ok);
    expq({3'h1, 21'h001234, 8'haa});
    expq({3'h1, 21'h001234, 8'hbb});
    expq({3'h1, 21'h0000ff, 8'hcc});
    expq({3'h1, 21'h000100, 8'hdd});
    expq({3'h1, 21'h0000ff, 8'hee});
    $display("t_cpu done");
  endtask
  task automatic t_dram();
    logic       ok;
    logic [7:0] d;
    stall_until <= cyc + 6000;
    send({8'h22, 8'h7a, 8'h1f, 8'hab, 8'hcd, 8'hd0, 8'hd1, 8'hd2, 8'hd3, 8'hd4, 8'hd5},
         1, ok);
    chk(ok, 1'b1);
    for (int i = 0; i < 6; i++) expq({3'h2, 21'h1fabcd + 21'(i), 8'hd0 + 8'(i)});
    chk(hold_max > 500, 1'b1);
    send({8'h22, 8'h7c}, 0, ok);
    send({8'h23}, 0, ok);
    m.rd(1'b0, d);
    chk(d, 8'h00);
    m.rd(1'b0, d);
    chk(d, 8'hcd);
    m.rd(1'b1, d);
    chk(d, 8'hce);
    m.stop();
    $display("t_dram done");
  endtask
  task automatic t_cmd();
    logic       ok;
    logic [7:0] d;
    logic [2:0] st[3] = '{3'h5, 3'h2, 3'h7};
    send({8'h22, 8'h7b, 8'h05, 8'h06}, 0, ok);
    chk(32'(q.size()) + 32'(cmd_req), 32'h0);
    stall_until <= cyc + 2000;
    m.stop();
    send({8'h22}, 1, ok);
    chk(ok, 1'b1);
    chk(32'(q.size()), 32'h2);
    expq({3'h3, 20'h00000, 1'b1, 8'h05});
    expq({3'h3, 20'h00000, 1'b0, 8'h06});
    foreach (st[k])
    begin
      {cmd_wait, cmd_invalid, cmd_nodata} <= st[k];
      rd_stat(8'h7d, d);
      chk(d, {st[k], 5'h00});
    end
    rd_stat(8'h7c, d);
    chk(d, 8'h3c);
    $display("t_cmd done");
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  initial
  begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    repeat (10) @(posedge clk);
    t_addr();
    t_cpu();
    t_dram();
    t_cmd();
    complete_run();
  end
  initial
  begin
    repeat (95000) @(posedge clk);
    error_cnt++;
    complete_run();
  end
endmodule // tb
